//--- design/het_edge_gen.sv
// one programmable high speed clock: rise, fall and polarity within the pixel period
module het_edge_gen
	import het_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic srst, // synchronous reset
	input wire logic ce, // clock enable
	input wire logic [POS_W-1:0] position, // current edge position
	input wire logic [POS_W-1:0] rise_pos, // position of the active edge
	input wire logic [POS_W-1:0] fall_pos, // position of the return edge
	input wire logic polarity, // 0 inverts
	output logic level // registered clock level
);
	logic active;

	// equal rise and fall means the clock never goes active
	always_comb begin
		if (rise_pos < fall_pos) begin
			active = (position >= rise_pos) && (position < fall_pos); // R23
		end else if (rise_pos > fall_pos) begin
			active = (position >= rise_pos) || (position < fall_pos); // R23
		end else begin
			active = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			level <= 1'b0;
		end else if (ce) begin
			level <= polarity ? active : ~active; // R7
		end
	end
endmodule

//--- design/het_timing_core.sv
// high speed edge timing core: edge positions, clock mapping, drive codes, line and field counters
//
// Behaviour
// (R1) each reference period is split into 64 edge positions
// (R2) halving setting counts every second reference period
// (R3) crystal drive output is the inverse of the reference clock
// (R4) reset gate clock has programmed rise, fall and polarity
// (R5) separate 6-bit rise and fall for clocks one, two, last, reset gate
// (R6) every edge setting selects position 0 to 63
// (R7) polarity 0 inverts the clock, 1 passes it
// (R8) precharge and data strobes each come from a 6-bit location
// (R9) drive code 0 tri-states, 1 to 3 steps, 4 to 7 maximum
// (R10) configuration code sits in bits 9 to 7 of register 0x23
// (R11) code 001: odd clocks copy one, even clocks are its inverse
// (R12) code 010: odd clocks copy one, even clocks copy two
// (R13) code 100: 3 copies 1, 2 and 4 invert; 7 copies 5, 6 and 8 invert
// (R14) host never writes codes 000, 011, 101, 110, 111
// (R15) pixel and line counters are 13 bits, up to 8192
// (R16) master mode: sync pulse clears counters and restarts sync outputs
// (R17) slave mode: external vertical and horizontal syncs align the timing
// (R18) edge generation is the same in master and slave mode
// (R19) host keeps edges out of the inhibit regions
// (R20) precharge inhibit zone 50 to 62 matters only in slave mode
// (R21) zone applies to rise or fall of clock one by mask polarity
// (R22) retime bit 1 makes the data zone a precharge zone
// (R23) clock goes active at rise position, returns at fall position
module het_timing_core
	import het_pkg::*;
(
	input wire logic CLOCK, // 10 MHz core clock
	input wire logic SRST, // synchronous reset, active high
	input wire logic CE, // clock enable, freezes all state when low
	input wire logic REFERENCE_CLOCK_IN, // reference clock pin
	input wire logic SERIAL_CLOCK, // 3-wire serial clock pin
	input wire logic SERIAL_DATA, // 3-wire serial data pin
	input wire logic SERIAL_LOAD, // 3-wire load pin, low during a frame
	input wire logic EXT_SYNC_IN, // master mode resync pulse pin
	input wire logic VERTICAL_SYNC_IN, // slave mode vertical sync pin
	input wire logic HORIZONTAL_SYNC_IN, // slave mode horizontal sync pin
	output logic CRYSTAL_DRIVE_OUT, // inverse of reference clock
	output logic RESET_GATE_CLOCK, // reset gate clock
	output logic [7:0] HORIZ_CLOCK, // horizontal clocks, bit 0 is clock one
	output logic LAST_HORIZ_CLOCK, // last horizontal clock
	output logic PRECHARGE_SAMPLE_STROBE, // precharge sample strobe
	output logic DATA_SAMPLE_STROBE, // data sample strobe
	output logic [N_DRV-1:0] DRIVE_OE_N, // driver enable, low while driving
	output logic [N_DRV*DRV_W-1:0] DRIVE_STEP, // current steps 0 to 4 per driver
	output logic VERTICAL_SYNC_OUT, // master mode vertical sync
	output logic HORIZONTAL_SYNC_OUT, // master mode horizontal sync
	output logic [CNT_W-1:0] PIXEL_COUNT, // pixel counter
	output logic [CNT_W-1:0] LINE_COUNT, // line counter
	output logic INHIBIT_WARN // clock one edge lies in an active inhibit zone
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int N_PIN = 7;
	// load idles high; resetting it low would show a false commit edge after reset
	localparam logic [N_PIN-1:0] PIN_IDLE = 7'h08;
	logic [N_PIN-1:0] pin_s1_reg;
	logic [N_PIN-1:0] pin_s2_reg;
	logic [N_PIN-1:0] pin_s3_reg;
	logic ref_s, sck_s, sdat_s, load_s, esync_s, vsync_s, hsync_s;
	logic ref_rise, sck_rise, load_rise, esync_rise, vsync_rise, hsync_rise;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			pin_s1_reg <= PIN_IDLE;
			pin_s2_reg <= PIN_IDLE;
			pin_s3_reg <= PIN_IDLE;
		end else if (CE) begin
			pin_s1_reg <= {HORIZONTAL_SYNC_IN, VERTICAL_SYNC_IN, EXT_SYNC_IN, SERIAL_LOAD,
				SERIAL_DATA, SERIAL_CLOCK, REFERENCE_CLOCK_IN};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign {hsync_s, vsync_s, esync_s, load_s, sdat_s, sck_s, ref_s} = pin_s2_reg;
	assign ref_rise = ref_s & ~pin_s3_reg[0];
	assign sck_rise = sck_s & ~pin_s3_reg[1];
	assign load_rise = load_s & ~pin_s3_reg[3];
	assign esync_rise = esync_s & ~pin_s3_reg[4];
	assign vsync_rise = vsync_s & ~pin_s3_reg[5];
	assign hsync_rise = hsync_s & ~pin_s3_reg[6];

	// ---------------------------------------------------------------
	// serial register port (write only)
	// ---------------------------------------------------------------
	logic [FRAME_W-1:0] shift_reg;
	logic [5:0] bit_cnt_reg;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;

	// a frame with fewer than 32 bits is dropped rather than half applied; a longer one writes its last 32 bits
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			shift_reg <= '0;
			bit_cnt_reg <= '0;
		end else if (CE) begin
			if (load_s) begin
				bit_cnt_reg <= '0;
			end else if (sck_rise) begin
				shift_reg <= {sdat_s, shift_reg[FRAME_W-1:1]};
				if (bit_cnt_reg != FRAME_BITS) begin
					bit_cnt_reg <= bit_cnt_reg + 6'h01;
				end
			end
		end
	end

	assign wr_en = CE && load_rise && (bit_cnt_reg == FRAME_BITS);
	assign wr_addr = shift_reg[ADDR_W-1:0];
	assign wr_data = shift_reg[FRAME_W-1:ADDR_W];

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	logic halve_reg;
	logic [2:0] hclk_cfg_reg;
	logic [DRV_W-1:0] drive_reg [N_DRV];
	logic [12:0] edge_reg [N_EDGE];
	logic [11:0] sample_reg;
	logic slave_reg, retime_reg, maskpol_reg;
	logic [CNT_W-1:0] line_len_reg;
	logic [CNT_W-1:0] field_len_reg;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			halve_reg <= 1'b0;
			hclk_cfg_reg <= HET_CFG_COMP;
			sample_reg <= SAMPLE_RST;
			{maskpol_reg, retime_reg, slave_reg} <= 3'h0;
			line_len_reg <= CNT_MAX;
			field_len_reg <= CNT_MAX;
		end else if (wr_en) begin
			unique case (wr_addr)
				REG_CLK_HALVE: halve_reg <= wr_data[0]; // R2
				REG_HCLK_CFG: hclk_cfg_reg <= wr_data[CFG_HI:CFG_LO]; // R10
				REG_SAMPLE: sample_reg <= wr_data[11:0]; // R8
				REG_SYNC_CTRL: begin
					slave_reg <= wr_data[SYNC_SLAVE_BIT];
					retime_reg <= wr_data[SYNC_RETIME_BIT];
					maskpol_reg <= wr_data[SYNC_MASKPOL_BIT];
				end
				REG_LINE_LEN: line_len_reg <= wr_data[CNT_W-1:0];
				REG_FIELD_LEN: field_len_reg <= wr_data[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_EDGE; gi++) begin : g_edge_reg
			always_ff @(posedge CLOCK) begin
				if (SRST) begin
					edge_reg[gi] <= EDGE_RST;
				end else if (wr_en && wr_addr == REG_EDGE_BASE + ADDR_W'(gi)) begin
					edge_reg[gi] <= wr_data[12:0]; // R5 R6
				end
			end
		end
		for (gi = 0; gi < N_DRV; gi++) begin : g_drive_reg
			localparam logic [7:0] DADDR = (gi < DRV_A_COUNT) ? REG_DRIVE_A : REG_DRIVE_B;
			localparam int DLO = (gi % DRV_A_COUNT) * DRV_W;
			always_ff @(posedge CLOCK) begin
				if (SRST) begin
					drive_reg[gi] <= DRV_RST;
				end else if (wr_en && wr_addr == DADDR) begin
					drive_reg[gi] <= wr_data[DLO +: DRV_W];
				end
			end
			// the pad offers at most four current steps
			always_ff @(posedge CLOCK) begin
				if (SRST) begin
					DRIVE_OE_N[gi] <= 1'b1;
					DRIVE_STEP[gi*DRV_W +: DRV_W] <= DRV_OFF;
				end else if (CE) begin
					DRIVE_OE_N[gi] <= (drive_reg[gi] == DRV_OFF); // R9
					DRIVE_STEP[gi*DRV_W +: DRV_W] <= (drive_reg[gi] > DRV_TOP) ? DRV_TOP : drive_reg[gi]; // R9
				end
			end
			a_drive_off: assert property (@(posedge CLOCK) disable iff (SRST)
				CE && drive_reg[gi] == DRV_OFF |=> DRIVE_OE_N[gi] && DRIVE_STEP[gi*DRV_W +: DRV_W] == DRV_OFF) // R9
				else $error("drive code 0 did not tri-state the driver");
		end
	endgenerate

	// ---------------------------------------------------------------
	// edge position counter
	// ---------------------------------------------------------------
	logic half_reg;
	logic period_start;
	logic [POS_W-1:0] pos_reg;

	// the position steps once per core clock, so the reference must be slow
	// enough for 64 core cycles per period to resolve every position
	assign period_start = ref_rise && (!halve_reg || half_reg); // R2

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			half_reg <= 1'b0;
			pos_reg <= POS_FIRST;
		end else if (CE) begin
			if (ref_rise) begin
				half_reg <= ~half_reg;
			end
			if (period_start) begin
				pos_reg <= POS_FIRST; // R1
			end else if (pos_reg != POS_LAST) begin
				pos_reg <= pos_reg + 6'h01; // R1
			end
		end
	end

	a_pos_restart: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && period_start |=> pos_reg == POS_FIRST) // R1
		else $error("edge position did not restart at period start");
	a_pos_step: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && !period_start && pos_reg != POS_LAST |=> pos_reg == $past(pos_reg) + 6'h01) // R1
		else $error("edge position did not advance by one");
	a_halve_skip: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && halve_reg && ref_rise && !half_reg |=> pos_reg != POS_FIRST) // R2
		else $error("halving did not skip a reference period");

	// ---------------------------------------------------------------
	// programmable clocks (same path in master and slave mode)
	// ---------------------------------------------------------------
	logic [N_EDGE-1:0] clk_lvl;

	generate
		for (gi = 0; gi < N_EDGE; gi++) begin : g_edge
			het_edge_gen u_edge (
				.clk(CLOCK),
				.srst(SRST),
				.ce(CE),
				.position(pos_reg), // R18
				.rise_pos(edge_reg[gi][EDGE_RISE_LO +: POS_W]), // R4 R5
				.fall_pos(edge_reg[gi][EDGE_FALL_LO +: POS_W]), // R4 R5
				.polarity(edge_reg[gi][EDGE_POL_BIT]), // R4 R7
				.level(clk_lvl[gi])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// output mapping; strobes delayed one stage to line up with the clocks
	// ---------------------------------------------------------------
	logic [7:0] hmap;
	logic shp_hit_reg, shd_hit_reg;
	logic c1, c2, c5;

	assign c1 = clk_lvl[CH_H1];
	assign c2 = clk_lvl[CH_H2];
	assign c5 = clk_lvl[CH_H5];

	// illegal codes park all eight HORIZ_CLOCK bits low
	always_comb begin
		unique case (hclk_cfg_reg)
			HET_CFG_COMP: hmap = {~c1, c1, ~c1, c1, ~c1, c1, ~c1, c1}; // R11
			HET_CFG_TWO: hmap = {c2, c1, c2, c1, c2, c1, c2, c1}; // R12
			HET_CFG_FOUR: hmap = {~c5, c5, ~c5, c5, ~c1, c1, ~c1, c1}; // R13
			default: hmap = 8'h00;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			shp_hit_reg <= 1'b0;
			shd_hit_reg <= 1'b0;
			HORIZ_CLOCK <= 8'h00;
			RESET_GATE_CLOCK <= 1'b0;
			LAST_HORIZ_CLOCK <= 1'b0;
			PRECHARGE_SAMPLE_STROBE <= 1'b0;
			DATA_SAMPLE_STROBE <= 1'b0;
			CRYSTAL_DRIVE_OUT <= 1'b1;
		end else if (CE) begin
			shp_hit_reg <= (pos_reg == sample_reg[SHP_LO +: POS_W]); // R8
			shd_hit_reg <= (pos_reg == sample_reg[SHD_LO +: POS_W]); // R8
			HORIZ_CLOCK <= hmap;
			RESET_GATE_CLOCK <= clk_lvl[CH_RG]; // R4
			LAST_HORIZ_CLOCK <= clk_lvl[CH_HL];
			PRECHARGE_SAMPLE_STROBE <= shp_hit_reg;
			DATA_SAMPLE_STROBE <= shd_hit_reg;
			CRYSTAL_DRIVE_OUT <= ~ref_s; // R3
		end
	end

	a_xtal_inverse: assert property (@(posedge CLOCK) disable iff (SRST)
		CE |=> CRYSTAL_DRIVE_OUT == !$past(ref_s)) // R3
		else $error("crystal drive is not the inverse of the reference");
	a_comp_mode: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && hclk_cfg_reg == HET_CFG_COMP |=> HORIZ_CLOCK[2] == HORIZ_CLOCK[0]
		&& HORIZ_CLOCK[7] == !HORIZ_CLOCK[6] && HORIZ_CLOCK[1] == !HORIZ_CLOCK[0]) // R11
		else $error("code 001 mapping wrong");
	a_two_mode: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && hclk_cfg_reg == HET_CFG_TWO |=> HORIZ_CLOCK[7] == $past(c2) && HORIZ_CLOCK[4] == $past(c1)) // R12
		else $error("code 010 mapping wrong");
	a_four_mode: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && hclk_cfg_reg == HET_CFG_FOUR |=> HORIZ_CLOCK[6] == $past(c5)
		&& HORIZ_CLOCK[3] == !$past(c1) && HORIZ_CLOCK[7] == !$past(c5)) // R13
		else $error("code 100 mapping wrong");
	a_shp_strobe: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && pos_reg == sample_reg[SHP_LO +: POS_W] ##1 CE |=> PRECHARGE_SAMPLE_STROBE) // R8
		else $error("precharge strobe missed its location");

	// ---------------------------------------------------------------
	// inhibit zone warning
	// ---------------------------------------------------------------
	logic [POS_W-1:0] h1_edge, shp_dist, shd_dist;
	logic shp_in, shd_in;

	assign h1_edge = maskpol_reg ? edge_reg[CH_H1][EDGE_FALL_LO +: POS_W]
		: edge_reg[CH_H1][EDGE_RISE_LO +: POS_W]; // R21
	assign shp_dist = h1_edge - sample_reg[SHP_LO +: POS_W];
	assign shd_dist = h1_edge - sample_reg[SHD_LO +: POS_W];
	assign shp_in = (shp_dist >= INH_LO) && (shp_dist <= INH_HI);
	assign shd_in = (shd_dist >= INH_LO) && (shd_dist <= INH_HI);

	// a warning only; the host still owns keeping edges out of these zones
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			INHIBIT_WARN <= 1'b0;
		end else if (CE) begin
			INHIBIT_WARN <= slave_reg && (shp_in || (retime_reg && shd_in)); // R19 R20 R22
		end
	end

	// ---------------------------------------------------------------
	// pixel and line counters, sync generation
	// ---------------------------------------------------------------
	logic line_restart, field_restart;
	logic line_end, field_end;

	assign line_restart = slave_reg ? hsync_rise : esync_rise; // R16 R17
	assign field_restart = slave_reg ? vsync_rise : esync_rise; // R16 R17
	assign line_end = (PIXEL_COUNT == line_len_reg);
	assign field_end = (LINE_COUNT == field_len_reg);

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			PIXEL_COUNT <= CNT_ZERO;
			LINE_COUNT <= CNT_ZERO;
		end else if (CE) begin
			if (line_restart) begin
				PIXEL_COUNT <= CNT_ZERO; // R16 R17
			end else if (period_start) begin
				PIXEL_COUNT <= line_end ? CNT_ZERO : PIXEL_COUNT + 13'h0001; // R15
			end
			if (field_restart) begin
				LINE_COUNT <= CNT_ZERO; // R16 R17
			end else if ((slave_reg && hsync_rise) || (!slave_reg && period_start && line_end)) begin
				LINE_COUNT <= field_end ? CNT_ZERO : LINE_COUNT + 13'h0001; // R15
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			HORIZONTAL_SYNC_OUT <= 1'b0;
			VERTICAL_SYNC_OUT <= 1'b0;
		end else if (CE) begin
			HORIZONTAL_SYNC_OUT <= !slave_reg && PIXEL_COUNT == CNT_ZERO; // R16
			VERTICAL_SYNC_OUT <= !slave_reg && LINE_COUNT == CNT_ZERO; // R16
		end
	end

	a_master_resync: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && !slave_reg && esync_rise |=> PIXEL_COUNT == CNT_ZERO && LINE_COUNT == CNT_ZERO) // R16
		else $error("master resync did not clear the pixel counter");
	a_slave_line: assert property (@(posedge CLOCK) disable iff (SRST)
		CE && slave_reg && hsync_rise |=> PIXEL_COUNT == CNT_ZERO) // R17
		else $error("slave horizontal sync did not align the pixel counter");
endmodule

//--- pkg/het_pkg.sv
// shared constants for the ccd high speed edge timing core
package het_pkg;
	// ---------------------------------------------------------------
	// timing core geometry
	// ---------------------------------------------------------------
	localparam int POS_W = 6;
	localparam logic [5:0] POS_LAST = 6'h3f;
	localparam logic [5:0] POS_FIRST = 6'h00;
	localparam int CNT_W = 13;
	localparam logic [12:0] CNT_MAX = 13'h1fff;
	localparam logic [12:0] CNT_ZERO = 13'h0000;
	localparam int N_EDGE = 5;
	localparam int N_DRV = 10;
	localparam int DRV_W = 3;
	localparam logic [2:0] DRV_OFF = 3'h0;
	localparam logic [2:0] DRV_TOP = 3'h4;
	localparam logic [5:0] INH_LO = 6'h32;
	localparam logic [5:0] INH_HI = 6'h3e;
	// ---------------------------------------------------------------
	// serial port: 8 bit address then 24 bit data, lsb first
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 24;
	localparam int FRAME_W = 32;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CLK_HALVE = 8'h0d;
	localparam logic [7:0] REG_HCLK_CFG = 8'h23;
	localparam logic [7:0] REG_DRIVE_A = 8'h35;
	localparam logic [7:0] REG_DRIVE_B = 8'h36;
	localparam logic [7:0] REG_EDGE_BASE = 8'h30;
	localparam logic [7:0] REG_SAMPLE = 8'h37;
	localparam logic [7:0] REG_SYNC_CTRL = 8'h3a;
	localparam logic [7:0] REG_LINE_LEN = 8'h3b;
	localparam logic [7:0] REG_FIELD_LEN = 8'h3c;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CFG_HI = 9;
	localparam int CFG_LO = 7;
	localparam int EDGE_RISE_LO = 0;
	localparam int EDGE_FALL_LO = 6;
	localparam int EDGE_POL_BIT = 12;
	localparam int SHP_LO = 0;
	localparam int SHD_LO = 6;
	localparam int SYNC_SLAVE_BIT = 0;
	localparam int SYNC_RETIME_BIT = 1;
	localparam int SYNC_MASKPOL_BIT = 2;
	localparam int DRV_A_COUNT = 8;
	// ---------------------------------------------------------------
	// edge channel indices and drive indices
	// ---------------------------------------------------------------
	localparam int CH_RG = 0;
	localparam int CH_H1 = 1;
	localparam int CH_H2 = 2;
	localparam int CH_HL = 3;
	localparam int CH_H5 = 4;
	localparam int DRV_RG = 0;
	localparam int DRV_HL = 1;
	localparam int DRV_H1 = 2;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [12:0] EDGE_RST = 13'h1400;
	localparam logic [11:0] SAMPLE_RST = 12'h800;
	localparam logic [2:0] DRV_RST = 3'h4;
	typedef enum logic [2:0] {
		HET_CFG_NONE = 3'b000,
		HET_CFG_COMP = 3'b001,
		HET_CFG_TWO = 3'b010,
		HET_CFG_FOUR = 3'b100
	} het_cfg_e;
endpackage

//--- verif/het_ccd_model.sv
// passive ccd model: counts rising edges on its horizontal clock one input
module het_ccd_model (
	input wire logic clk, // core clock
	input wire logic clock_one, // horizontal clock one as seen by the sensor
	output int rises // rising edges counted so far
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_reg = 1'b0;
	initial rises = 0;
	// non-blocking so the bench reads a settled count at any edge
	always @(posedge clk) begin
		if (clock_one && !last_reg) rises <= rises + 1;
		last_reg <= clock_one;
	end
endmodule

//--- verif/het_timing_core_tb_top.sv
// self-checking bench for the high speed edge timing core
module het_timing_core_tb_top import het_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, srst = 1'b1, refc = 1'b0, ref_run = 1'b1, sck = 1'b0, sdat = 1'b0, sload = 1'b1;
	logic [2:0] syn = 3'h0;
	logic cdo, rgc, hlc, pss, dss, vso, hso, warn;
	logic [7:0] hc;
	logic [N_DRV-1:0] oe_n, eo;
	logic [N_DRV*DRV_W-1:0] step, es, codes;
	logic [CNT_W-1:0] pix, line;
	logic [15:0] lfsr = 16'h8688;
	logic [23:0] da;
	logic [5:0] db;
	logic [2:0] modes[3] = '{3'h1, 3'h2, 3'h4};
	int failures = 0, num_checks = 0, cyc = 0, rises;
	int tbl[5][4] = '{'{0, 15, 40, 0}, '{1, 15, 40, 1}, '{5, 15, 40, 0}, '{1, 0, 15, 0}, '{3, 0, 15, 1}};
	wire [4:0] chv = {hc[4], hlc, hc[1], hc[0], rgc};
	het_timing_core het_timing_core_inst (
		.CLOCK(clk), .SRST(srst), .CE(1'b1), .REFERENCE_CLOCK_IN(refc), .SERIAL_CLOCK(sck),
		.SERIAL_DATA(sdat), .SERIAL_LOAD(sload), .EXT_SYNC_IN(syn[2]), .VERTICAL_SYNC_IN(syn[1]),
		.HORIZONTAL_SYNC_IN(syn[0]), .CRYSTAL_DRIVE_OUT(cdo), .RESET_GATE_CLOCK(rgc), .HORIZ_CLOCK(hc),
		.LAST_HORIZ_CLOCK(hlc), .PRECHARGE_SAMPLE_STROBE(pss), .DATA_SAMPLE_STROBE(dss),
		.DRIVE_OE_N(oe_n), .DRIVE_STEP(step), .VERTICAL_SYNC_OUT(vso), .HORIZONTAL_SYNC_OUT(hso),
		.PIXEL_COUNT(pix), .LINE_COUNT(line), .INHIBIT_WARN(warn));
	het_ccd_model het_ccd_model_inst (.clk(clk), .clock_one(hc[0]), .rises(rises));
	// ----
	// tasks and model
	// ----
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (exp !== got) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [15:0] nxt(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic wr(logic [7:0] a, logic [23:0] d);
		logic [31:0] f;
		f = {d, a};
		sload <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			sdat <= f[i];
			tick(3);
			sck <= 1'b1;
			tick(3);
			sck <= 1'b0;
		end
		tick(3);
		sload <= 1'b1;
		tick(6);
	endtask
	task automatic pulse(int b);
		syn[b] <= 1'b1;
		tick(4);
		syn[b] <= 1'b0;
		tick(6);
	endtask
	// high cycles per window; a halved period parks on position 63 for 64 extra cycles
	function automatic int exp_hi(int r, int f, int p, int hv);
		int a;
		a = (r < f) ? f - r : ((r > f) ? 64 - r + f : 0);
		if (hv != 0 && r > f) a += 64;
		return p ? a : (hv ? 128 : 64) - a;
	endfunction
	function automatic logic [7:0] map(logic [2:0] m, logic [7:0] h);
		case (m)
			3'h1: return {4{~h[0], h[0]}};
			3'h2: return {4{h[1], h[0]}};
			3'h4: return {~h[4], h[4], ~h[4], h[4], ~h[0], h[0], ~h[0], h[0]};
			default: return 8'h00;
		endcase
	endfunction
	task automatic edge_case(int ch, int r, int f, int p, int hv);
		int hi = 0, w = hv ? 128 : 64, r0;
		wr(REG_EDGE_BASE + 8'(ch), {11'h000, 1'(p), 6'(f), 6'(r)});
		tick(2 * w);
		r0 = rises;
		repeat (w) begin
			@(posedge clk);
			hi += int'(chv[ch] === 1'b1);
		end
		chk("high cycles", 32'(exp_hi(r, f, p, hv)), 32'(hi));
		if (ch == CH_H1 && hv == 0) chk("ccd clock one edges", hi % 64 != 0, 32'(rises - r0));
	endtask
	task automatic mode_case(logic [2:0] m);
		int bad = 0;
		wr(REG_HCLK_CFG, {14'h0000, m, 7'h00});
		tick(4);
		repeat (64) begin
			@(posedge clk);
			bad += int'(hc !== map(m, hc));
		end
		chk("mapped clocks", 0, 32'(bad));
	endtask
	task automatic strobe_case(int pl, int dl);
		int t_h = 0, t_p = 0, t_d = 0;
		logic last;
		wr(REG_SAMPLE, {12'h000, 6'(dl), 6'(pl)});
		tick(128);
		last = hc[0];
		for (int i = 0; i < 64; i++) begin
			@(posedge clk);
			if (hc[0] === 1'b1 && last === 1'b0) t_h = i;
			if (pss === 1'b1) t_p = i;
			if (dss === 1'b1) t_d = i;
			last = hc[0];
		end
		chk("precharge place", 32'((pl - 5 + 64) % 64), 32'((t_p - t_h + 64) % 64));
		chk("data place", 32'((dl - 5 + 64) % 64), 32'((t_d - t_h + 64) % 64));
	endtask
	task automatic count_run(int n);
		logic [12:0] lp, ll;
		lp = pix;
		ll = line;
		repeat (n) begin
			@(posedge clk);
			if (pix !== lp) chk("pixel step", 32'((lp + 1) % 4), 32'(pix));
			if (line !== ll) chk("line step", 32'((ll + 1) % 3), 32'(line));
			lp = pix;
			ll = line;
		end
	endtask
	// ----
	// main sequence
	// ----
	initial forever #50 clk = ~clk;
	// a 64 cycle reference period gives exactly one cycle per edge position
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ref_run && cyc % 32 == 0) refc <= ~refc;
		if (!srst && cyc % 32 == 16) chk("crystal drive", !refc, cdo);
	end
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		tick(3);
		chk("drive enable", 0, 32'(oe_n));
		chk("drive step", 32'({N_DRV{DRV_RST}}), 32'(step));
		for (int k = 0; k < 4; k++) begin
			lfsr = nxt(lfsr);
			da = (k == 0) ? 24'hfac688 : {lfsr, lfsr[15:8] ^ lfsr[7:0]};
			db = (k == 0) ? 6'h07 : lfsr[13:8];
			wr(REG_DRIVE_A, da);
			wr(REG_DRIVE_B, {18'h00000, db});
			codes = {db, da};
			for (int i = 0; i < N_DRV; i++) begin
				eo[i] = (codes[3*i+:3] == 3'h0);
				es[3*i+:3] = (codes[3*i+:3] > 3'h4) ? 3'h4 : codes[3*i+:3];
			end
			chk("drive enable", 32'(eo), 32'(oe_n));
			chk("drive step", 32'(es), 32'(step));
		end
		for (int k = 0; k < 10; k++) begin
			lfsr = nxt(lfsr);
			wr(REG_HCLK_CFG, {14'h0000, (k % 5 == 2) ? 3'h2 : ((k % 5 == 4) ? 3'h4 : 3'h1), 7'h00});
			edge_case(k % 5, k == 6 ? 63 : lfsr[5:0], k == 6 ? 0 : (k == 5 ? lfsr[5:0] : lfsr[11:6]), lfsr[12], 0);
		end
		foreach (modes[i]) mode_case(modes[i]);
		edge_case(CH_H1, 5, 30, 1, 0);
		strobe_case(15, 40);
		for (int k = 0; k < 5; k++) begin
			wr(REG_SAMPLE, {12'h000, 6'(tbl[k][2]), 6'(tbl[k][1])});
			wr(REG_SYNC_CTRL, 24'(tbl[k][0]));
			tick(8);
			chk("inhibit warn", tbl[k][3], warn);
		end
		chk("sync outs in slave", 0, {vso, hso});
		pulse(1);
		pulse(0);
		pulse(0);
		chk("slave line", 2, 32'(line));
		edge_case(CH_H1, 20, 10, 1, 0);
		wr(REG_SYNC_CTRL, 24'h000000);
		wr(REG_LINE_LEN, 24'h000003);
		wr(REG_FIELD_LEN, 24'h000002);
		// stop the reference so no period start races the resync check
		ref_run <= 1'b0;
		tick(4);
		pulse(2);
		chk("resync counters", 0, {pix, line});
		chk("master syncs", 3, {vso, hso});
		ref_run <= 1'b1;
		count_run(900);
		wr(REG_CLK_HALVE, 24'h000001);
		edge_case(CH_H1, 40, 5, 0, 1);
		give_verdict();
	end
endmodule
